// *** hw/snpes_pkg.sv ***
package snpes_pkg;

  // opcodes handled by the sequencer
  localparam logic [7:0] OP_WR_EN     = 8'h06;
  localparam logic [7:0] OP_WR_DIS    = 8'h04;
  localparam logic [7:0] OP_GET_FEAT  = 8'h0f;
  localparam logic [7:0] OP_RD_X1A    = 8'h03;
  localparam logic [7:0] OP_RD_X1B    = 8'h0b;
  localparam logic [7:0] OP_RD_X4     = 8'h6b;
  localparam logic [7:0] OP_LOAD_X1   = 8'h02;
  localparam logic [7:0] OP_LOAD_X4   = 8'h32;
  localparam logic [7:0] OP_RAND_X1   = 8'h84;
  localparam logic [7:0] OP_RAND_X4   = 8'h34;
  localparam logic [7:0] OP_PROG_EXEC = 8'h10;
  localparam logic [7:0] OP_BLK_ERASE = 8'hd8;

  // frame layout, in serial clocks
  localparam logic [4:0] OPC_BITS      = 5'h08;
  localparam logic [4:0] FEAT_ADR_BITS = 5'h08;
  localparam logic [4:0] COL_ADR_BITS  = 5'h10;
  localparam logic [4:0] ROW_ADR_BITS  = 5'h18;
  localparam logic [4:0] DUMMY_CLKS    = 5'h08;

  // cache and address widths
  localparam int          CACHE_LEN    = 2176;
  localparam int          COL_W        = 12;
  localparam int          ROW_W        = 17;
  localparam logic [12:0] CACHE_END    = 13'h880;
  localparam logic [7:0]  CACHE_ERASED = 8'hff;

  // status byte at the status feature address
  localparam logic [7:0] FEAT_STATUS  = 8'hc0;
  localparam int         STAT_OIP_BIT = 0;
  localparam int         STAT_WEL_BIT = 1;
  localparam logic       RST_WEL      = 1'b0;

  // busy times
  localparam int CLK_FREQ_MHZ  = 10;
  localparam int PROG_TIME_US  = 800;
  localparam int ERASE_TIME_US = 10000;
  localparam int TMR_W         = 17;

  typedef enum logic [2:0]
  {
    ST_OPC   = 3'h0,
    ST_ADDR  = 3'h1,
    ST_DUMMY = 3'h3,
    ST_DOUT  = 3'h2,
    ST_DIN   = 3'h6,
    ST_SKIP  = 3'h7
  } snpes_st_e;

  // request to the array: one-cycle strobes with the row
  typedef struct packed
  {
    logic             prog;
    logic             erase;
    logic [ROW_W-1:0] row;
  } snpes_arr_s;

  // synchronised pin view with serial clock edges
  typedef struct packed
  {
    logic       cs_n;
    logic       rise;
    logic       fall;
    logic [3:0] io;
  } snpes_pin_s;

  function automatic logic is_load(input logic [7:0] op);
    return (op == OP_LOAD_X1) || (op == OP_LOAD_X4) || (op == OP_RAND_X1) || (op == OP_RAND_X4);
  endfunction

  function automatic logic is_quad(input logic [7:0] op);
    return (op == OP_LOAD_X4) || (op == OP_RAND_X4) || (op == OP_RD_X4);
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    return (op == OP_RD_X1A) || (op == OP_RD_X1B) || (op == OP_RD_X4);
  endfunction

endpackage

// *** hw/snpes_pinsync.sv ***
`timescale 1ns/100ps
`default_nettype none
module snpes_pinsync
  import snpes_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_cs_n,
  input  wire logic       i_sck,
  input  wire logic [3:0] i_io,
  output snpes_pin_s      o_pin
);

  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic       sck_old_q;

  // two flops on every pin; idle chip select reads high
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_q    <= 6'h20;
      sync_q    <= 6'h20;
      sck_old_q <= 1'b0;
    end
    else
    begin
      meta_q    <= {i_cs_n, i_sck, i_io};
      sync_q    <= meta_q;
      sck_old_q <= sync_q[4];
    end
  end

  // edges taken from the second stage only
  assign o_pin.cs_n = sync_q[5];
  assign o_pin.rise = sync_q[4] & ~sck_old_q;
  assign o_pin.fall = ~sync_q[4] & sck_old_q;
  assign o_pin.io   = sync_q[3:0];

endmodule
`default_nettype wire

// *** hw/snpes_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module snpes_top
  import snpes_pkg::*;
#(
  parameter int unsigned PROG_CYCLES  = PROG_TIME_US * CLK_FREQ_MHZ,
  parameter int unsigned ERASE_CYCLES = ERASE_TIME_US * CLK_FREQ_MHZ
)
(
  input  wire logic       I_MCLK,
  input  wire logic       I_RST,
  input  wire logic       I_CS_N,
  input  wire logic       I_SCK,
  input  wire logic [3:0] I_IO,
  output logic      [3:0] O_IO,
  output logic      [3:0] O_IO_OE,
  output snpes_arr_s      O_ARR,
  output logic            O_BUSY,
  output logic            O_WEL
);

  snpes_pin_s        pin;
  snpes_st_e         st_q;
  logic [4:0]        cnt_q;
  logic [4:0]        len_q;
  logic [23:0]       sh_q;
  logic [23:0]       sh_d;
  logic [7:0]        op_q;
  logic [7:0]        opc;
  logic [12:0]       col_q;
  logic [7:0]        cache_q [CACHE_LEN];
  logic              wel_q;
  logic              busy_q;
  logic [TMR_W-1:0]  tmr_q;
  snpes_arr_s        arr_q;
  logic [3:0]        io_q;
  logic [3:0]        oe_q;
  logic [7:0]        ob_q;
  logic [2:0]        ocnt_q;
  logic              act;
  logic              opc_done;
  logic              addr_done;
  logic              din_done;
  logic              dout_last;
  logic              exec_ok;
  logic [7:0]        din_byte;
  logic [7:0]        obyte;
  logic [7:0]        cur_b;

  snpes_pinsync u_sync
  (
    .i_clk  (I_MCLK),
    .i_rst  (I_RST),
    .i_cs_n (I_CS_N),
    .i_sck  (I_SCK),
    .i_io   (I_IO),
    .o_pin  (pin)
  );

  // frame events on serial clock edges inside a frame
  assign act       = ~pin.cs_n & pin.rise;
  assign opc       = {sh_q[6:0], pin.io[0]};
  assign opc_done  = act && (st_q == ST_OPC) && (cnt_q == OPC_BITS - 5'h01);
  assign addr_done = act && (st_q == ST_ADDR) && (cnt_q == len_q - 5'h01);
  assign din_done  = act && (st_q == ST_DIN) && (cnt_q == (is_quad(op_q) ? 5'h01 : 5'h07));
  assign din_byte  = is_quad(op_q) ? {sh_q[3:0], pin.io} : {sh_q[6:0], pin.io[0]};
  assign sh_d      = (is_quad(op_q) && st_q == ST_DIN) ? {sh_q[19:0], pin.io} : {sh_q[22:0], pin.io[0]};
  assign exec_ok   = wel_q && !busy_q;

  // command, address and data phases of one frame
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST || pin.cs_n)
    begin
      st_q  <= ST_OPC;
      cnt_q <= 5'h00;
      len_q <= COL_ADR_BITS;
      sh_q  <= 24'h000000;
      op_q  <= 8'h00;
    end
    else if (act)
    begin
      sh_q  <= sh_d;
      cnt_q <= cnt_q + 5'h01;
      case (st_q)
        ST_OPC:
          if (cnt_q == OPC_BITS - 5'h01)
          begin
            op_q  <= opc;
            cnt_q <= 5'h00;
            if (opc == OP_GET_FEAT)
            begin
              st_q  <= ST_ADDR;
              len_q <= FEAT_ADR_BITS;
            end
            else if (is_read(opc) || (is_load(opc) && !busy_q))
            begin
              st_q  <= ST_ADDR;
              len_q <= COL_ADR_BITS;
            end
            else if (opc == OP_PROG_EXEC || opc == OP_BLK_ERASE)
            begin
              st_q  <= ST_ADDR;
              len_q <= ROW_ADR_BITS;
            end
            else
              st_q <= ST_SKIP;
          end
        ST_ADDR:
          if (cnt_q == len_q - 5'h01)
          begin
            cnt_q <= 5'h00;
            if (op_q == OP_GET_FEAT)
              st_q <= ST_DOUT;
            else if (is_read(op_q))
              st_q <= ST_DUMMY;
            else if (is_load(op_q))
              st_q <= ST_DIN;
            else
              st_q <= ST_SKIP;
          end
        ST_DUMMY:
          if (cnt_q == DUMMY_CLKS - 5'h01)
          begin
            cnt_q <= 5'h00;
            st_q  <= ST_DOUT;
          end
        ST_DIN:
          if (din_done)
            cnt_q <= 5'h00;
        default:
          cnt_q <= 5'h00;
      endcase
    end
  end

  // column pointer saturates at the cache end so extra bytes fall away
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
      col_q <= 13'h0000;
    else if (addr_done && (is_load(op_q) || is_read(op_q)))
      col_q <= {1'b0, sh_d[COL_W-1:0]};
    else if ((din_done || (dout_last && is_read(op_q))) && col_q < CACHE_END)
      col_q <= col_q + 13'h0001;
  end

  // cache store; plain load erases it first, random load patches it
  always_ff @(posedge I_MCLK)
  begin
    if (opc_done && !busy_q && (opc == OP_LOAD_X1 || opc == OP_LOAD_X4))
    begin
      for (int i = 0; i < CACHE_LEN; i++)
        cache_q[i] <= CACHE_ERASED;
    end
    else if (din_done && col_q < CACHE_END)
      cache_q[col_q[COL_W-1:0]] <= din_byte;
  end

  // write enable latch; consumed when an array operation starts
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
      wel_q <= RST_WEL;
    else if (opc_done && opc == OP_WR_EN)
      wel_q <= 1'b1;
    else if (opc_done && opc == OP_WR_DIS)
      wel_q <= 1'b0;
    else if (addr_done && (op_q == OP_PROG_EXEC || op_q == OP_BLK_ERASE) && exec_ok)
      wel_q <= 1'b0;
  end

  // array strobe and self-timed busy period
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      busy_q <= 1'b0;
      tmr_q  <= '0;
      arr_q  <= '0;
    end
    else
    begin
      arr_q.prog  <= 1'b0;
      arr_q.erase <= 1'b0;
      if (addr_done && (op_q == OP_PROG_EXEC || op_q == OP_BLK_ERASE) && exec_ok)
      begin
        busy_q      <= 1'b1;
        arr_q.prog  <= (op_q == OP_PROG_EXEC);
        arr_q.erase <= (op_q == OP_BLK_ERASE);
        arr_q.row   <= sh_d[ROW_W-1:0];
        tmr_q       <= (op_q == OP_PROG_EXEC) ? TMR_W'(PROG_CYCLES - 1) : TMR_W'(ERASE_CYCLES - 1);
      end
      else if (busy_q)
      begin
        if (tmr_q == '0)
          busy_q <= 1'b0;
        else
          tmr_q <= tmr_q - TMR_W'(1);
      end
    end
  end

  // byte to send: status or cache, erased value past the end
  always_comb
  begin
    if (op_q == OP_GET_FEAT)
    begin
      obyte               = 8'h00;
      obyte[STAT_OIP_BIT] = busy_q;
      obyte[STAT_WEL_BIT] = wel_q;
    end
    else if (col_q < CACHE_END)
      obyte = cache_q[col_q[COL_W-1:0]];
    else
      obyte = CACHE_ERASED;
    cur_b = (ocnt_q == 3'h0) ? obyte : ob_q;
  end

  assign dout_last = (st_q == ST_DOUT) && pin.fall && !pin.cs_n
                     && (ocnt_q == (is_quad(op_q) ? 3'h1 : 3'h7));

  // output shifter on falling serial clock, msb first
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST || pin.cs_n)
    begin
      io_q   <= 4'h0;
      oe_q   <= 4'h0;
      ob_q   <= 8'h00;
      ocnt_q <= 3'h0;
    end
    else if (st_q == ST_DOUT && pin.fall)
    begin
      ocnt_q <= dout_last ? 3'h0 : ocnt_q + 3'h1;
      if (is_quad(op_q))
      begin
        oe_q <= 4'hf;
        io_q <= cur_b[7:4];
        ob_q <= {cur_b[3:0], 4'h0};
      end
      else
      begin
        oe_q <= 4'h2; // single line drives io1 only
        io_q <= {2'b00, cur_b[7], 1'b0};
        ob_q <= {cur_b[6:0], 1'b0};
      end
    end
  end

  assign O_IO    = io_q;
  assign O_IO_OE = oe_q;
  assign O_ARR   = arr_q;
  assign O_BUSY  = busy_q;
  assign O_WEL   = wel_q;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  sequence s_exec_go;
    addr_done && (op_q == OP_PROG_EXEC || op_q == OP_BLK_ERASE) && exec_ok;
  endsequence

  sequence s_exec_busy;
    busy_q && (arr_q.prog || arr_q.erase);
  endsequence

  wel_set_a:   assert property (opc_done && opc == OP_WR_EN |=> wel_q) else $error("latch not set");
  wel_clear_a: assert property (opc_done && opc == OP_WR_DIS |=> !wel_q) else $error("latch not cleared");
  exec_gate_a: assert property ($rose(arr_q.prog || arr_q.erase) |-> $past(wel_q)) else $error("start without latch");
  exec_busy_a: assert property (s_exec_go |=> s_exec_busy) else $error("execute did not start");
  busy_hold_a: assert property (busy_q && tmr_q != '0 |=> busy_q) else $error("busy dropped early");
  busy_end_a:  assert property (busy_q && tmr_q == '0 && !$rose(busy_q) |=> !busy_q) else $error("busy stuck");
  cs_end_a:    assert property (pin.cs_n |=> st_q == ST_OPC && !din_done) else $error("frame not ended");
  col_sat_a:   assert property (col_q >= CACHE_END |=> col_q == CACHE_END || $past(addr_done)) else $error("col past end");
  quad_out_a:  assert property (st_q == ST_DOUT && pin.fall && !pin.cs_n && is_quad(op_q) |=> O_IO_OE == 4'hf)
                 else $error("quad read not on four lines");
  fill_ff_a:   assert property (opc_done && opc == OP_LOAD_X1 && !busy_q |=> cache_q[CACHE_LEN-1] == CACHE_ERASED)
                 else $error("cache not erased");

endmodule
`default_nettype wire

// *** verif/snpes_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module snpes_host
  import snpes_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [3:0] i_io,
  output logic            o_cs_n,
  output logic            o_sck,
  output logic [3:0]      o_io
);
  // 5 clocks a phase: the pin sync needs at least 3
  localparam int HALF = 5;
  logic [3:0] smp;

  // idle: cs high, sck parked low
  initial
  begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_io   = 4'h0;
  end

  // drive on the fall, sample on the rise
  task automatic bit_x(input logic [3:0] v);
    @(negedge i_clk);
    o_sck = 1'b0;
    o_io  = v;
    repeat (HALF) @(negedge i_clk);
    o_sck = 1'b1;
    smp   = i_io;
    repeat (HALF - 1) @(negedge i_clk);
  endtask

  // x1 msb first on io0, x4 high nibble first
  task automatic put_b(input logic [7:0] b, input logic quad);
    if (quad)
    begin
      bit_x(b[7:4]);
      bit_x(b[3:0]);
    end
    else
      for (int i = 7; i >= 0; i--)
        bit_x({{3{~b[i]}}, b[i]});
  endtask

  // released lines carry the inverse of the last value
  task automatic get_b(input logic quad, output logic [7:0] b);
    for (int i = 0; i < (quad ? 2 : 8); i++)
    begin
      bit_x(~o_io);
      b = quad ? {b[3:0], smp} : {b[6:0], smp[1]};
    end
  endtask

  // opcode, then 4 dummy bits and the column
  task automatic open_f(input logic [7:0] op, input logic col_on, input logic [11:0] col);
    @(negedge i_clk);
    o_cs_n = 1'b0;
    put_b(op, 1'b0);
    if (col_on)
    begin
      put_b({4'h0, col[11:8]}, 1'b0);
      put_b(col[7:0], 1'b0);
    end
  endtask

  // cs rising ends the frame and any load in it
  task automatic close_f();
    @(negedge i_clk);
    o_sck = 1'b0;
    repeat (HALF) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_io   = ~o_io;
    repeat (2 * HALF) @(negedge i_clk);
  endtask

  task automatic cmd(input logic [7:0] op);
    open_f(op, 1'b0, 12'h000);
    close_f();
  endtask

  // execute or erase: 24 address bits
  task automatic cmd_row(input logic [7:0] op, input logic [23:0] a);
    open_f(op, 1'b0, 12'h000);
    for (int i = 2; i >= 0; i--)
      put_b(a[8*i +: 8], 1'b0);
    close_f();
  endtask

  // n bytes, then nb stray bits that must be dropped
  task automatic load(input logic [7:0] op, input logic [11:0] col, input logic [7:0] d [4],
                      input int n, input int nb);
    open_f(op, 1'b1, col);
    for (int i = 0; i < n; i++)
      put_b(d[i], op == OP_LOAD_X4 || op == OP_RAND_X4);
    for (int i = 0; i < nb; i++)
      bit_x(4'h1);
    close_f();
  endtask

  task automatic read(input logic [7:0] op, input logic [11:0] col, output logic [7:0] d [4]);
    open_f(op, 1'b1, col);
    for (int i = 0; i < 8; i++)
      bit_x(~o_io);
    for (int i = 0; i < 4; i++)
      get_b(op == OP_RD_X4, d[i]);
    close_f();
  endtask

  task automatic status(output logic [7:0] s);
    open_f(OP_GET_FEAT, 1'b0, 12'h000);
    put_b(FEAT_STATUS, 1'b0);
    get_b(1'b0, s);
    close_f();
  endtask
endmodule
`default_nettype wire

// *** verif/tb_spi_nand_program_erase_seq.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_spi_nand_program_erase_seq;
  import snpes_pkg::*;
  // short busy times, still long enough to try a load and poll once inside
  localparam int unsigned PCYC = 800;
  localparam int unsigned ECYC = 1000;

  logic             I_MCLK;
  logic             I_RST;
  logic             I_CS_N;
  logic             I_SCK;
  logic [3:0]       I_IO;
  logic [3:0]       O_IO;
  logic [3:0]       O_IO_OE;
  snpes_arr_s       O_ARR;
  logic             O_BUSY;
  logic             O_WEL;
  int               err_count = 0;
  int               cmp_count = 0;
  int               prog_n    = 0;
  int               erase_n   = 0;
  int               busy_n    = 0;
  logic [ROW_W-1:0] row_seen;
  logic [7:0]       d [4];
  logic [7:0]       st;

  snpes_top #(.PROG_CYCLES(PCYC), .ERASE_CYCLES(ECYC)) u_dut
  (
    .I_MCLK  (I_MCLK),
    .I_RST   (I_RST),
    .I_CS_N  (I_CS_N),
    .I_SCK   (I_SCK),
    .I_IO    (I_IO),
    .O_IO    (O_IO),
    .O_IO_OE (O_IO_OE),
    .O_ARR   (O_ARR),
    .O_BUSY  (O_BUSY),
    .O_WEL   (O_WEL)
  );

  snpes_host u_host
  (
    .i_clk  (I_MCLK),
    .i_io   (O_IO),
    .o_cs_n (I_CS_N),
    .o_sck  (I_SCK),
    .o_io   (I_IO)
  );

  initial
  begin
    I_MCLK = 1'b0;
    forever #50 I_MCLK = ~I_MCLK;
  end

  // strobes and busy length as seen at the ports
  always @(posedge I_MCLK)
  begin
    if (O_ARR.prog === 1'b1 || O_ARR.erase === 1'b1)
      row_seen <= O_ARR.row;
    if (O_ARR.prog === 1'b1)
      prog_n <= prog_n + 1;
    if (O_ARR.erase === 1'b1)
      erase_n <= erase_n + 1;
    if (O_BUSY === 1'b1)
      busy_n <= busy_n + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic t_latch();
    u_host.cmd(OP_WR_EN);
    chk(O_WEL, 1, "latch set");
    u_host.status(st);
    chk(st, 8'h02, "latch status");
    u_host.cmd(OP_WR_DIS);
    chk(O_WEL, 0, "latch clear");
  endtask

  task automatic t_refuse();
    u_host.cmd_row(OP_PROG_EXEC, 24'h000040);
    u_host.cmd_row(OP_BLK_ERASE, 24'h000040);
    chk(prog_n + erase_n, 0, "strobe without latch");
    chk(O_BUSY, 0, "busy without latch");
  endtask

  // load at the cache end: the byte past the last column is lost
  task automatic t_load();
    d = '{8'h11, 8'h22, 8'h33, 8'h00};
    u_host.cmd(OP_WR_EN);
    u_host.load(OP_LOAD_X1, 12'h87e, d, 3, 0);
    u_host.read(OP_RD_X1A, 12'h87d, d);
    chk({d[0], d[1], d[2], d[3]}, 32'hff1122ff, "x1 load");
  endtask

  // random loads keep the rest; stray bits at cs high dropped
  task automatic t_random();
    d = '{8'ha5, 8'h00, 8'h00, 8'h00};
    u_host.load(OP_RAND_X1, 12'h87d, d, 1, 4);
    u_host.read(OP_RD_X1A, 12'h87d, d);
    chk({d[0], d[1], d[2], d[3]}, 32'ha51122ff, "x1 random");
    d = '{8'h5a, 8'hc3, 8'h00, 8'h00};
    u_host.load(OP_RAND_X4, 12'h87e, d, 2, 0);
    u_host.read(OP_RD_X4, 12'h87d, d);
    chk({d[0], d[1], d[2], d[3]}, 32'ha55ac3ff, "x4 random");
    d = '{8'h3c, 8'h00, 8'h00, 8'h00};
    u_host.load(OP_LOAD_X4, 12'h87f, d, 1, 0);
    u_host.read(OP_RD_X1B, 12'h87d, d);
    chk({d[0], d[1], d[2], d[3]}, 32'hffff3cff, "x4 load");
  endtask

  // latch, row command, busy span, status while busy and after
  task automatic run_array(input logic [7:0] op, input logic [23:0] a, input int unsigned cyc);
    int b0;
    u_host.cmd(OP_WR_EN);
    b0 = busy_n;
    u_host.cmd_row(op, a);
    chk(row_seen, a[ROW_W-1:0], "row");
    chk(O_WEL, 0, "latch used");
    // a plain load while busy must neither erase nor write the cache
    d = '{8'h00, 8'h00, 8'h00, 8'h00};
    u_host.load(OP_LOAD_X1, 12'h87f, d, 1, 0);
    u_host.status(st);
    chk(st, 8'h01, "busy status");
    for (int i = 0; i < 1000 && O_BUSY !== 1'b0; i++)
      @(negedge I_MCLK);
    chk(busy_n - b0, cyc, "busy span");
    u_host.status(st);
    chk(st, 8'h00, "done status");
    u_host.read(OP_RD_X1A, 12'h87e, d);
    chk({d[0], d[1], d[2], d[3]}, 32'hff3cffff, "load while busy");
  endtask

  task automatic t_prog();
    run_array(OP_PROG_EXEC, 24'h01abcd, PCYC);
    chk(prog_n, 1, "prog strobe");
  endtask

  task automatic t_erase();
    run_array(OP_BLK_ERASE, 24'h00ffc0, ECYC);
    chk(prog_n, 1, "no extra program");
    chk(erase_n, 1, "one erase");
  endtask

  initial
  begin
    I_RST = 1'b1;
    repeat (6) @(negedge I_MCLK);
    I_RST = 1'b0;
    repeat (4) @(negedge I_MCLK);
    chk({O_IO_OE, O_BUSY, O_WEL, O_ARR.prog, O_ARR.erase}, 0, "reset");
    t_latch();
    t_refuse();
    t_load();
    t_random();
    t_prog();
    t_erase();
    complete_run();
  end

  // watchdog: the whole sequence needs well under this
  initial
  begin
    repeat (40000) @(posedge I_MCLK);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
